// *** rlu_unit.sv ***
// Rotate-left datapath slice: full rotate and byte, nibble and word rotate-in operations.
// Function
// - The full rotate writes bits 63..32 of the doubled destination shifted left by the low five source bits.
// - With carry writing, carry is the last bit rotated out for a nonzero amount, else destination bit 31.
// - The indexed byte rotate yields destination bits 23..0 above the source byte chosen by the index.
// - The indexed nibble rotate yields destination bits 27..0 above the source nibble chosen by the index.
// - The single-operand byte rotate takes the byte selected by the immediately preceding byte prefix.
// - The single-operand nibble rotate takes the nibble selected by the immediately preceding nibble prefix.
// - The single-operand word rotate takes the word selected by the immediately preceding word prefix.
`timescale 1ns/10ps
module rlu_unit
	import rlu_pkg::*;
(
	input  wire logic                       clk,
	input  wire logic                       arst_n,
	input  wire logic                       anyIssue,
	input  wire logic                       opValid,
	input  wire rlu_pkg::rlu_op_t           opCode,
	input  wire logic [rlu_pkg::DATA_W-1:0] dVal,
	input  wire logic [rlu_pkg::DATA_W-1:0] sVal,
	input  wire logic [rlu_pkg::IDX_W-1:0]  immIdx,
	input  wire logic                       writeCarry,
	input  wire logic                       pfxValid,
	input  wire rlu_pkg::rlu_pfx_t          pfxKind,
	input  wire logic [rlu_pkg::DATA_W-1:0] pfxSrc,
	input  wire logic [rlu_pkg::IDX_W-1:0]  pfxIdx,
	output logic                            resValid_r,
	output logic      [rlu_pkg::DATA_W-1:0] result_r,
	output logic                            carryWe_r,
	output logic                            carryOut_r
);
	import rlu_pkg::*;

	function automatic logic [BYTE_W-1:0] byteOf(input logic [DATA_W-1:0] s, input logic [BIDX_W-1:0] i);
		byteOf = s[i*BYTE_W +: BYTE_W];
	endfunction : byteOf

	function automatic logic [NIB_W-1:0] nibOf(input logic [DATA_W-1:0] s, input logic [NIDX_W-1:0] i);
		nibOf = s[i*NIB_W +: NIB_W];
	endfunction : nibOf

	function automatic logic [WORD_W-1:0] wordOf(input logic [DATA_W-1:0] s, input logic [WIDX_W-1:0] i);
		wordOf = s[i*WORD_W +: WORD_W];
	endfunction : wordOf

	rlu_state_t             state_r;
	rlu_state_t             state_nxt;
	rlu_pfx_t               selKind_r;
	rlu_pfx_t               selKind_nxt;
	logic [DATA_W-1:0]      selSrc_r;
	logic [DATA_W-1:0]      selSrc_nxt;
	logic [IDX_W-1:0]       selIdx_r;
	logic [IDX_W-1:0]       selIdx_nxt;
	logic                   resValid_nxt;
	logic [DATA_W-1:0]      result_nxt;
	logic                   carryWe_nxt;
	logic                   carryOut_nxt;
	logic [DATA_W-1:0]      fullRot;
	logic                   fullCarry;
	logic [DATA_W-1:0]      pfxData;
	logic [IDX_W-1:0]       pfxSel;

	rlu_rotator rlu_rotator_i (
		.dIn      (dVal),
		.amt      (sVal[AMT_W-1:0]),
		.rotOut   (fullRot),
		.carryOut (fullCarry)
	);

	// A prefix selection lives only until the next issued instruction.
	always_comb begin
		state_nxt   = state_r;
		selKind_nxt = selKind_r;
		selSrc_nxt  = selSrc_r;
		selIdx_nxt  = selIdx_r;
		unique case (state_r)
			ST_IDLE: begin
				if (pfxValid) begin
					state_nxt = ST_ARMED;
				end
			end
			ST_ARMED: begin
				if (anyIssue && !pfxValid) begin
					state_nxt   = ST_IDLE;
					selKind_nxt = PFX_NONE;
				end
			end
		endcase
		if (pfxValid) begin
			selKind_nxt = pfxKind;
			selSrc_nxt  = pfxSrc;
			selIdx_nxt  = pfxIdx;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r   <= ST_IDLE;
			selKind_r <= PFX_NONE;
			selSrc_r  <= RES_RST;
			selIdx_r  <= '0;
		end else begin
			state_r   <= state_nxt;
			selKind_r <= selKind_nxt;
			selSrc_r  <= selSrc_nxt;
			selIdx_r  <= selIdx_nxt;
		end
	end

	// Without a matching prefix the single-operand forms fall back to field zero of the source operand.
	always_comb begin
		pfxData = sVal;
		pfxSel  = '0;
		if (state_r == ST_ARMED) begin
			pfxData = selSrc_r;
			pfxSel  = selIdx_r;
		end
	end

	always_comb begin
		resValid_nxt = opValid;
		result_nxt   = result_r;
		carryWe_nxt  = 1'h0;
		carryOut_nxt = carryOut_r;
		if (opValid) begin
			unique case (opCode)
				OP_FULL: begin
					result_nxt  = fullRot;
					carryWe_nxt = writeCarry;
					if (writeCarry) begin
						carryOut_nxt = fullCarry;
					end
				end
				OP_BYTE_IMM: begin
					result_nxt = {dVal[DATA_W-BYTE_W-1:0], byteOf(sVal, immIdx[BIDX_W-1:0])};
				end
				OP_NIB_IMM: begin
					result_nxt = {dVal[DATA_W-NIB_W-1:0], nibOf(sVal, immIdx[NIDX_W-1:0])};
				end
				OP_BYTE_PFX: begin
					result_nxt = {dVal[DATA_W-BYTE_W-1:0],
						byteOf(selKind_r == PFX_BYTE ? pfxData : sVal,
							selKind_r == PFX_BYTE ? pfxSel[BIDX_W-1:0] : '0)};
				end
				OP_NIB_PFX: begin
					result_nxt = {dVal[DATA_W-NIB_W-1:0],
						nibOf(selKind_r == PFX_NIB ? pfxData : sVal,
							selKind_r == PFX_NIB ? pfxSel[NIDX_W-1:0] : '0)};
				end
				OP_WORD_PFX: begin
					result_nxt = {dVal[DATA_W-WORD_W-1:0],
						wordOf(selKind_r == PFX_WORD ? pfxData : sVal,
							selKind_r == PFX_WORD ? pfxSel[WIDX_W-1:0] : '0)};
				end
				default: begin
					result_nxt = result_r;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			resValid_r <= FLAG_RST;
			result_r   <= RES_RST;
			carryWe_r  <= FLAG_RST;
			carryOut_r <= FLAG_RST;
		end else begin
			resValid_r <= resValid_nxt;
			result_r   <= result_nxt;
			carryWe_r  <= carryWe_nxt;
			carryOut_r <= carryOut_nxt;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	logic armedByte;
	logic armedNib;
	logic armedWord;
	assign armedByte = (state_r == ST_ARMED) && (selKind_r == PFX_BYTE);
	assign armedNib  = (state_r == ST_ARMED) && (selKind_r == PFX_NIB);
	assign armedWord = (state_r == ST_ARMED) && (selKind_r == PFX_WORD);

	a_full_result: assert property (opValid && opCode == OP_FULL |=>
		result_r == (($past(dVal) << $past(sVal[4:0])) | ($past(dVal) >> (6'h20 - {1'h0, $past(sVal[4:0])}))))
		else $error("full rotate result wrong");
	a_full_carry: assert property (opValid && opCode == OP_FULL && writeCarry |=>
		carryWe_r && carryOut_r == (($past(sVal[4:0]) == 5'h0) ? $past(dVal[31]) :
			1'($past(dVal) >> (6'h20 - {1'h0, $past(sVal[4:0])}))))
		else $error("full rotate carry wrong");
	a_carry_hold: assert property (!(opValid && opCode == OP_FULL && writeCarry) |=>
		!carryWe_r && $stable(carryOut_r))
		else $error("carry changed without request");
	a_byte_imm: assert property (opValid && opCode == OP_BYTE_IMM |=>
		result_r == {$past(dVal[23:0]), 8'($past(sVal) >> (6'h8 * $past(immIdx[1:0])))})
		else $error("indexed byte rotate wrong");
	a_nib_imm: assert property (opValid && opCode == OP_NIB_IMM |=>
		result_r == {$past(dVal[27:0]), 4'($past(sVal) >> (6'h4 * $past(immIdx)))})
		else $error("indexed nibble rotate wrong");
	a_byte_prefix: assert property (armedByte && opValid && opCode == OP_BYTE_PFX |=>
		result_r == {$past(dVal[23:0]), 8'($past(selSrc_r) >> (6'h8 * $past(selIdx_r[1:0])))})
		else $error("prefixed byte rotate wrong");
	a_nib_prefix: assert property (armedNib && opValid && opCode == OP_NIB_PFX |=>
		result_r == {$past(dVal[27:0]), 4'($past(selSrc_r) >> (6'h4 * $past(selIdx_r)))})
		else $error("prefixed nibble rotate wrong");
	a_word_prefix: assert property (armedWord && opValid && opCode == OP_WORD_PFX |=>
		result_r == {$past(dVal[15:0]), ($past(selIdx_r[0]) ? $past(selSrc_r[31:16]) : $past(selSrc_r[15:0]))})
		else $error("prefixed word rotate wrong");
	a_prefix_once: assert property (state_r == ST_ARMED && anyIssue && !pfxValid |=>
		state_r == ST_IDLE ##1 (state_r == ST_IDLE || $past(pfxValid)))
		else $error("prefix selection outlived next instruction");
	a_valid_timing: assert property (opValid |=> resValid_r ##1 (resValid_r == $past(opValid)))
		else $error("result valid timing wrong");

	c_full_carry: cover property (opValid && opCode == OP_FULL && writeCarry && sVal[4:0] != 5'h0);
	c_byte_prefix: cover property (pfxValid && pfxKind == PFX_BYTE ##1 opValid && opCode == OP_BYTE_PFX);
	c_word_prefix: cover property (pfxValid && pfxKind == PFX_WORD ##1 opValid && opCode == OP_WORD_PFX);
	c_nib_imm: cover property (opValid && opCode == OP_NIB_IMM && immIdx == 3'h7);
endmodule : rlu_unit

// *** rlu_pkg.sv ***
// Shared widths, field positions, reset values and encodings of the rotate-left unit.
package rlu_pkg;
	localparam int unsigned DATA_W   = 32;
	localparam int unsigned AMT_W    = 5;
	localparam int unsigned BYTE_W   = 8;
	localparam int unsigned NIB_W    = 4;
	localparam int unsigned WORD_W   = 16;
	localparam int unsigned BIDX_W   = 2;
	localparam int unsigned NIDX_W   = 3;
	localparam int unsigned WIDX_W   = 1;
	localparam int unsigned IDX_W    = 3;
	localparam int unsigned MSB_POS  = 31;
	localparam logic [31:0] RES_RST  = 32'h0000_0000;
	localparam logic        FLAG_RST = 1'h0;
	localparam int unsigned LATENCY  = 1;

	typedef enum logic [2:0] {
		OP_FULL     = 3'h0,
		OP_BYTE_IMM = 3'h1,
		OP_NIB_IMM  = 3'h2,
		OP_BYTE_PFX = 3'h3,
		OP_NIB_PFX  = 3'h4,
		OP_WORD_PFX = 3'h5
	} rlu_op_t;

	typedef enum logic [1:0] {
		PFX_NONE = 2'h0,
		PFX_BYTE = 2'h1,
		PFX_NIB  = 2'h2,
		PFX_WORD = 2'h3
	} rlu_pfx_t;

	typedef enum logic [0:0] {
		ST_IDLE  = 1'h0,
		ST_ARMED = 1'h1
	} rlu_state_t;
endpackage : rlu_pkg

// *** rlu_rotator.sv ***
// Full 32-bit rotate left by a variable amount, with the carry of the last bit out.
`timescale 1ns/10ps
module rlu_rotator
	import rlu_pkg::*;
(
	input  wire logic [rlu_pkg::DATA_W-1:0] dIn,
	input  wire logic [rlu_pkg::AMT_W-1:0]  amt,
	output logic      [rlu_pkg::DATA_W-1:0] rotOut,
	output logic                            carryOut
);
	logic [2*DATA_W-1:0] wide;

	always_comb begin
		wide     = {dIn, dIn} << amt;
		rotOut   = wide[2*DATA_W-1:DATA_W];
		// The last bit out lands at the bottom of the upper half; a zero amount moves nothing.
		carryOut = (amt != '0) ? wide[DATA_W] : dIn[MSB_POS];
	end
endmodule : rlu_rotator

// *** rlu_regfile_model.sv ***
// Destination register of the register file, written back from the unit's result.
`timescale 1ns/10ps
module rlu_regfile_model (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        resValid_r,
	input  wire logic [31:0] result_r,
	output logic      [31:0] destReg
);
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) destReg <= 32'h0;
		else if (resValid_r) destReg <= result_r;
	end
endmodule : rlu_regfile_model

// *** rotate_left_unit_tb.sv ***
// Self-checking testbench of the rotate-left unit.
`timescale 1ns/10ps
module rotate_left_unit_tb;
	import rlu_pkg::*;
	logic        clk = 0, arst_n = 0, anyIssue = 0, opValid = 0, writeCarry = 0, pfxValid = 0;
	rlu_op_t     opCode = OP_FULL;
	rlu_pfx_t    pfxKind = PFX_NONE;
	logic [31:0] dVal = 32'h0, sVal = 32'h0, pfxSrc = 32'h0, result_r, destReg, e;
	logic [2:0]  immIdx = 3'h0, pfxIdx = 3'h0;
	logic        resValid_r, carryWe_r, carryOut_r;
	int          nFail = 0, nChecks = 0;
	always #4 clk = ~clk;
	rlu_unit rlu_unit_i (.clk(clk), .arst_n(arst_n), .anyIssue(anyIssue), .opValid(opValid), .opCode(opCode),
		.dVal(dVal), .sVal(sVal), .immIdx(immIdx), .writeCarry(writeCarry), .pfxValid(pfxValid),
		.pfxKind(pfxKind), .pfxSrc(pfxSrc), .pfxIdx(pfxIdx), .resValid_r(resValid_r), .result_r(result_r),
		.carryWe_r(carryWe_r), .carryOut_r(carryOut_r));
	rlu_regfile_model rlu_regfile_model_i (.clk(clk), .arst_n(arst_n), .resValid_r(resValid_r),
		.result_r(result_r), .destReg(destReg));
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		nChecks++;
		if (seen !== exp) begin
			nFail++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// Issues one op, then samples the registered answer one cycle later.
	task issue(input rlu_op_t op, input logic [31:0] d, input logic [31:0] s, input logic [2:0] idx, input logic wc);
		@(posedge clk);
		opValid    <= 1'h1;
		anyIssue   <= 1'h1;
		pfxValid   <= 1'h0;
		opCode     <= op;
		dVal       <= d;
		sVal       <= s;
		immIdx     <= idx;
		writeCarry <= wc;
		@(posedge clk);
		opValid    <= 1'h0;
		anyIssue   <= 1'h0;
		writeCarry <= 1'h0;
		#1;
		check("valid", {31'h0, resValid_r}, 32'h1);
	endtask : issue
	// Leaves the prefix raised; the following issue lowers it at the next edge.
	task prefix(input rlu_pfx_t k, input logic [31:0] src, input logic [2:0] idx);
		@(posedge clk);
		pfxValid <= 1'h1;
		anyIssue <= 1'h1;
		pfxKind  <= k;
		pfxSrc   <= src;
		pfxIdx   <= idx;
	endtask : prefix
	task test_full;
		int a;
		logic [31:0] d;
		// Bits 31 and 0 differ so that a zero amount shows which one the carry takes.
		d = 32'h9234_5670;
		for (int j = 0; j < 5; j++) begin
			a = (j == 4) ? 33 : (j == 3 ? 31 : j * 3);
			issue(OP_FULL, d, a, 3'h0, 1'b1);
			e = 32'(({d, d} << a[4:0]) >> 32);
			check("full result", result_r, e);
			check("carry write", {31'h0, carryWe_r}, 32'h1);
			check("carry", {31'h0, carryOut_r}, (a[4:0] != 0) ? {31'h0, e[0]} : {31'h0, d[31]});
			#8;
			check("write back", destReg, e);
		end
		issue(OP_FULL, ~d, 32'h3, 3'h0, 1'b0);
		e = 32'(({~d, ~d} << 3) >> 32);
		check("no carry result", result_r, e);
		check("no carry write", {31'h0, carryWe_r}, 32'h0);
		// The last rotate by one left bit 31 in the carry, and it must stand.
		check("carry held", {31'h0, carryOut_r}, {31'h0, d[31]});
		$display("test full done");
	endtask : test_full
	task test_imm;
		logic [31:0] d, s;
		d = 32'hc3a5_1e0f;
		s = 32'h8765_4321;
		for (int i = 0; i < 4; i++) begin
			issue(OP_BYTE_IMM, d, s, i[2:0], 1'b0);
			check("byte imm", result_r, {d[23:0], s[8*i+:8]});
		end
		issue(OP_BYTE_IMM, d, s, 3'h5, 1'b0);
		check("byte imm top index bit", result_r, {d[23:0], s[15:8]});
		for (int i = 0; i < 8; i++) begin
			issue(OP_NIB_IMM, d, s, i[2:0], 1'b0);
			check("nibble imm", result_r, {d[27:0], s[4*i+:4]});
		end
		$display("test imm done");
	endtask : test_imm
	task test_pfx;
		logic [31:0] d, s, src;
		d = 32'h1357_9bdf;
		s = 32'h0a0b_0c0d;
		src = 32'hfedc_ba98;
		prefix(PFX_BYTE, src, 3'h2);
		issue(OP_BYTE_PFX, d, s, 3'h0, 1'b0);
		check("byte pfx", result_r, {d[23:0], src[23:16]});
		prefix(PFX_NIB, src, 3'h5);
		issue(OP_NIB_PFX, d, s, 3'h0, 1'b0);
		check("nibble pfx", result_r, {d[27:0], src[23:20]});
		prefix(PFX_WORD, src, 3'h1);
		issue(OP_WORD_PFX, d, s, 3'h0, 1'b0);
		check("word pfx", result_r, {d[15:0], src[31:16]});
		prefix(PFX_BYTE, src, 3'h3);
		@(posedge clk);
		pfxValid <= 0;
		issue(OP_BYTE_PFX, d, s, 3'h0, 1'b0);
		check("stale pfx", result_r, {d[23:0], s[7:0]});
		$display("test pfx done");
	endtask : test_pfx
	task test_odd;
		logic [31:0] d, s, src;
		d = 32'h0246_8ace;
		s = 32'h1133_5577;
		src = 32'h99bb_ddff;
		// A nibble prefix leaves a byte rotate on field zero and is used up by it.
		prefix(PFX_NIB, src, 3'h3);
		issue(OP_BYTE_PFX, d, s, 3'h0, 1'b0);
		check("mismatched pfx", result_r, {d[23:0], s[7:0]});
		issue(OP_NIB_PFX, d, s, 3'h0, 1'b0);
		check("unarmed nibble", result_r, {d[27:0], s[3:0]});
		issue(OP_WORD_PFX, d, s, 3'h0, 1'b0);
		check("unarmed word", result_r, {d[15:0], s[15:0]});
		issue(rlu_op_t'(3'h6), s, d, 3'h0, 1'b0);
		check("illegal op held", result_r, {d[15:0], s[15:0]});
		$display("test odd done");
	endtask : test_odd
	// A reset in mid-run clears the outputs, the write-back and an armed prefix.
	task test_reset;
		logic [31:0] d, s;
		d = 32'ha468_ace1;
		s = 32'h0f1e_2d3c;
		issue(OP_FULL, d, 32'h1, 3'h0, 1'b1);
		check("carry before reset", {31'h0, carryOut_r}, {31'h0, d[31]});
		prefix(PFX_BYTE, s, 3'h1);
		@(posedge clk);
		pfxValid <= 1'h0;
		anyIssue <= 1'h0;
		arst_n   <= 1'h0;
		@(posedge clk);
		#1;
		check("reset result", result_r, RES_RST);
		check("reset carry", {31'h0, carryOut_r}, 32'h0);
		check("reset write back", destReg, 32'h0);
		@(posedge clk);
		arst_n <= 1'h1;
		issue(OP_BYTE_PFX, d, s, 3'h0, 1'b0);
		check("pfx cleared by reset", result_r, {d[23:0], s[7:0]});
		$display("test reset done");
	endtask : test_reset
	task stop_test;
		$display("checks %0d mismatches %0d", nChecks, nFail);
		if (nFail == 0 && nChecks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : stop_test
	initial begin
		#20000;
		nFail++;
		stop_test();
	end
	initial begin
		repeat (3) @(posedge clk);
		arst_n <= 1;
		test_full();
		test_imm();
		test_pfx();
		test_odd();
		test_reset();
		stop_test();
	end
endmodule : rotate_left_unit_tb
